// ### logic/cfs_consts.svh
/*
 cpu register set constants: flag bit positions, reset values, stack layout.
 assumes inclusion by the design file only.
*/
`ifndef CFS_CONSTS_SVH
`define CFS_CONSTS_SVH
`define CFS_FLAG_H 4
`define CFS_FLAG_I 3
`define CFS_FLAG_N 2
`define CFS_FLAG_Z 1
`define CFS_FLAG_C 0
`define CFS_FLAGS_RESET 8'hE8
`define CFS_FLAGS_FIXED 8'hE0
`define CFS_SP_RESET 16'h01FF
`define CFS_SP_FIXED 16'h0180
`define CFS_SP_LOW_MASK 7'h7F
`define CFS_CALL_BYTES 3'h2
`define CFS_IRQ_BYTES 3'h5
`endif

// ### logic/cfs_pkg.sv
/*
 types for the cpu flag and stack pointer register set.
 assumes the constants header is included alongside.
*/
package cfs_pkg;
   // stack sequencer commands issued by the execution unit
   typedef enum logic [2:0] {
      CFS_CMD_NONE = 3'h0,
      CFS_CMD_CALL = 3'h1,
      CFS_CMD_RET = 3'h2,
      CFS_CMD_IRQ = 3'h3,
      CFS_CMD_RETURN_FROM_INTERRUPT_OP = 3'h4
   } cfs_cmd_t;
   // sequencer states, one-hot
   typedef enum logic [2:0] {
      CFS_ST_IDLE = 3'b001,
      CFS_ST_PUSH = 3'b010,
      CFS_ST_POP = 3'b100
   } cfs_state_t;
endpackage

// ### logic/cfs_regs.sv
/*
 cpu programmer-visible registers: accumulator, two index registers,
 instruction pointer, condition flags and 128-byte wrapping stack pointer,
 plus the sequencer that pushes and pops call and interrupt frames.
 assumes a synchronous byte stack memory written in the cycle of mem_we and
 returning read data one cycle after mem_re; decode/alu drive one-cycle strobes.
*/
`include "cfs_consts.svh"
module cfs_regs (
   input wire logic clk_sys, // cpu clock
   input wire logic arst_n, // mcu reset, active low
   input wire logic acc_we, // load accumulator
   input wire logic [7:0] acc_wdata,
   input wire logic idx1_we, // load first index register
   input wire logic [7:0] idx1_wdata,
   input wire logic idx2_we, // load second index register
   input wire logic [7:0] idx2_wdata,
   input wire logic ip_we, // load instruction pointer
   input wire logic [15:0] ip_wdata,
   input wire logic alu_valid, // alu result strobe
   input wire logic [7:0] alu_result,
   input wire logic alu_is_add, // add or add-with-carry
   input wire logic alu_half_carry, // carry out of bit 3
   input wire logic alu_carry_upd, // alu updates carry
   input wire logic alu_carry,
   input wire logic carry_set_op,
   input wire logic carry_clear_op,
   input wire logic mask_interrupts_op,
   input wire logic unmask_interrupts_op,
   input wire logic flags_we, // pop or direct flag write
   input wire logic [7:0] flags_wdata,
   input wire logic stack_pointer_restore_op,
   input wire logic load_op, // write pointer low seven bits
   input wire logic [7:0] load_data,
   input wire logic push_byte, // single push of push_data
   input wire logic [7:0] push_data,
   input wire logic pop_byte, // single pop, returned on pop_data
   input wire cfs_pkg::cfs_cmd_t cmd, // frame command, one-cycle
   input wire logic irq_req, // external interrupt request pulse
   output logic [7:0] accumulator,
   output logic [7:0] index1,
   output logic [7:0] index2,
   output logic [15:0] instruction_pointer,
   output logic [7:0] condition_flags,
   output logic [15:0] stack_top_pointer,
   output logic [7:0] pop_data, // byte from last single pop
   output logic pop_valid,
   output logic irq_take, // pending request may be serviced
   output logic busy, // frame sequencer active
   output logic mem_we,
   output logic mem_re,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata
);
   import cfs_pkg::*;

   cfs_state_t state; // sequencer state
   logic [2:0] cnt; // bytes left in frame
   logic [2:0] frame_len; // length of current frame
   logic is_irq; // current frame is interrupt type
   logic rd_pend; // read data due this cycle
   logic [2:0] rd_slot; // frame slot of pending read
   logic single_pop; // pending read is a single pop
   logic [6:0] sp_low; // writable pointer bits
   logic irq_pending; // latched request
   logic [15:0] ret_ip; // return address being rebuilt
   logic [7:0] push_byte_sel; // byte pushed this cycle
   logic [2:0] slot; // frame slot index
   logic [4:0] flag_low; // writable flag bits, top three are constant
   logic saved_mask; // mask as it stood before interrupt entry

   assign stack_top_pointer = `CFS_SP_FIXED | {9'h000, sp_low};
   assign condition_flags = {3'h7, flag_low};
   assign busy = (state != CFS_ST_IDLE);
   // slot counts 0..len-1 from the first pushed byte
   assign slot = frame_len - cnt;

   // frame byte chooser; second index deliberately absent
   always_comb begin
      case (slot)
         3'h0: push_byte_sel = is_irq ? instruction_pointer[7:0] : instruction_pointer[7:0];
         3'h1: push_byte_sel = instruction_pointer[15:8];
         3'h2: push_byte_sel = index1;
         3'h3: push_byte_sel = accumulator;
         // stacked mask is the pre-entry one, else return could never unmask
         3'h4: push_byte_sel = {condition_flags[7:4], saved_mask, condition_flags[2:0]};
         default: push_byte_sel = 8'h00;
      endcase
   end

   // memory strobes: pushes write at pointer, pops read at pointer + 1
   always_comb begin
      mem_we = 1'b0;
      mem_re = 1'b0;
      mem_wdata = push_data;
      mem_addr = stack_top_pointer;
      if (state == CFS_ST_PUSH) begin
         mem_we = 1'b1;
         mem_wdata = push_byte_sel;
      end else if (state == CFS_ST_POP) begin
         mem_re = 1'b1;
         mem_addr = `CFS_SP_FIXED | {9'h000, sp_low + 7'h01};
      end else if (push_byte) begin
         mem_we = 1'b1;
      end else if (pop_byte) begin
         mem_re = 1'b1;
         mem_addr = `CFS_SP_FIXED | {9'h000, sp_low + 7'h01};
      end
   end

   // frame sequencer
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state <= CFS_ST_IDLE;
         cnt <= 3'h0;
         frame_len <= 3'h0;
         saved_mask <= 1'b0;
         is_irq <= 1'b0;
      end else begin
         case (state)
            CFS_ST_IDLE: begin
               case (cmd)
                  CFS_CMD_CALL: begin
                     state <= CFS_ST_PUSH;
                     frame_len <= `CFS_CALL_BYTES;
                     cnt <= `CFS_CALL_BYTES;
                     is_irq <= 1'b0;
                  end
                  CFS_CMD_IRQ: begin
                     state <= CFS_ST_PUSH;
                     frame_len <= `CFS_IRQ_BYTES;
                     saved_mask <= condition_flags[`CFS_FLAG_I];
                     cnt <= `CFS_IRQ_BYTES;
                     is_irq <= 1'b1;
                  end
                  CFS_CMD_RET: begin
                     state <= CFS_ST_POP;
                     frame_len <= `CFS_CALL_BYTES;
                     cnt <= `CFS_CALL_BYTES;
                     is_irq <= 1'b0;
                  end
                  CFS_CMD_RETURN_FROM_INTERRUPT_OP: begin
                     state <= CFS_ST_POP;
                     frame_len <= `CFS_IRQ_BYTES;
                     cnt <= `CFS_IRQ_BYTES;
                     is_irq <= 1'b1;
                  end
                  default: state <= CFS_ST_IDLE;
               endcase
            end
            CFS_ST_PUSH, CFS_ST_POP: begin
               cnt <= cnt - 3'h1;
               if (cnt == 3'h1) begin
                  state <= CFS_ST_IDLE;
               end
            end
            default: state <= CFS_ST_IDLE;
         endcase
      end
   end

   // pointer: wraps within seven bits, no overflow flag
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sp_low <= `CFS_SP_LOW_MASK;
      end else if (stack_pointer_restore_op) begin
         sp_low <= `CFS_SP_LOW_MASK;
      end else if (state == CFS_ST_PUSH || (state == CFS_ST_IDLE && push_byte)) begin
         sp_low <= sp_low - 7'h01;
      end else if (state == CFS_ST_POP || (state == CFS_ST_IDLE && pop_byte)) begin
         sp_low <= sp_low + 7'h01;
      end else if (load_op) begin
         sp_low <= load_data[6:0];
      end
   end

   // pop return tracking: pops come back in reverse of push order
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rd_pend <= 1'b0;
         rd_slot <= 3'h0;
         single_pop <= 1'b0;
      end else begin
         rd_pend <= mem_re;
         rd_slot <= cnt - 3'h1;
         single_pop <= (state == CFS_ST_IDLE);
      end
   end

   // single pop result
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pop_data <= 8'h00;
         pop_valid <= 1'b0;
      end else begin
         pop_valid <= rd_pend && single_pop;
         if (rd_pend && single_pop) begin
            pop_data <= mem_rdata;
         end
      end
   end

   // accumulator
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         accumulator <= 8'h00;
      end else if (rd_pend && !single_pop && rd_slot == 3'h3) begin
         accumulator <= mem_rdata;
      end else if (acc_we) begin
         accumulator <= acc_wdata;
      end
   end

   // index registers; second one only by explicit writes
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         index1 <= 8'h00;
         index2 <= 8'h00;
      end else begin
         if (rd_pend && !single_pop && rd_slot == 3'h2) begin
            index1 <= mem_rdata;
         end else if (idx1_we) begin
            index1 <= idx1_wdata;
         end
         if (idx2_we) begin
            index2 <= idx2_wdata;
         end
      end
   end

   // instruction pointer, rebuilt bytewise on return
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         instruction_pointer <= 16'h0000;
         ret_ip <= 16'h0000;
      end else begin
         if (rd_pend && !single_pop && rd_slot == 3'h1) begin
            ret_ip[15:8] <= mem_rdata;
         end
         if (rd_pend && !single_pop && rd_slot == 3'h0) begin
            instruction_pointer <= {ret_ip[15:8], mem_rdata};
         end else if (ip_we) begin
            instruction_pointer <= ip_wdata;
         end
      end
   end

   // flags; alu updates lose to pops and direct writes
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         flag_low <= 5'(`CFS_FLAGS_RESET);
      end else if (rd_pend && !single_pop && rd_slot == 3'h4) begin
         flag_low <= mem_rdata[4:0];
      end else if (flags_we) begin
         flag_low <= flags_wdata[4:0];
      end else begin
         if (cmd == CFS_CMD_IRQ && state == CFS_ST_IDLE) begin
            flag_low[`CFS_FLAG_I] <= 1'b1;
         end else if (mask_interrupts_op) begin
            flag_low[`CFS_FLAG_I] <= 1'b1;
         end else if (unmask_interrupts_op) begin
            flag_low[`CFS_FLAG_I] <= 1'b0;
         end
         if (alu_valid) begin
            flag_low[`CFS_FLAG_N] <= alu_result[7];
            flag_low[`CFS_FLAG_Z] <= (alu_result == 8'h00);
            if (alu_is_add) begin
               flag_low[`CFS_FLAG_H] <= alu_half_carry;
            end
         end
         if (carry_set_op) begin
            flag_low[`CFS_FLAG_C] <= 1'b1;
         end else if (carry_clear_op) begin
            flag_low[`CFS_FLAG_C] <= 1'b0;
         end else if (alu_carry_upd) begin
            flag_low[`CFS_FLAG_C] <= alu_carry;
         end
      end
   end

   // pending request; a new request beats the service clear
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq_pending <= 1'b0;
      end else if (irq_req) begin
         irq_pending <= 1'b1;
      end else if (cmd == CFS_CMD_IRQ && state == CFS_ST_IDLE) begin
         irq_pending <= 1'b0;
      end
   end

   // no priority term here: unmasked means take, even inside a handler
   assign irq_take = irq_pending && !condition_flags[`CFS_FLAG_I] && !busy;

   sequence s_irq_start;
      (state == CFS_ST_IDLE) && (cmd == CFS_CMD_IRQ);
   endsequence
   sequence s_five_writes;
      mem_we [*5];
   endsequence

   AST_FLAG_FIXED: assert property (@(posedge clk_sys) disable iff (!arst_n)
      condition_flags[7:5] == 3'h7) else $error("flag top bits not one");
   AST_SP_FIXED: assert property (@(posedge clk_sys) disable iff (!arst_n)
      stack_top_pointer[15:7] == 9'h003) else $error("pointer upper bits wrong");
   AST_IRQ_FIVE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_irq_start |=> s_five_writes ##1 !busy) else $error("interrupt frame not five bytes");
   AST_IRQ_MASK: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (s_irq_start and !flags_we) |=> condition_flags[3]) else $error("mask not set on entry");
   AST_IRQ_FIRST: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_irq_start |=> mem_wdata == instruction_pointer[7:0] && mem_addr == stack_top_pointer)
      else $error("first frame byte not pointer low");
   AST_PUSH_DEC: assert property (@(posedge clk_sys) disable iff (!arst_n)
      mem_we && !stack_pointer_restore_op |=> stack_top_pointer[6:0] == $past(stack_top_pointer[6:0]) - 7'h01)
      else $error("push did not decrement");
   AST_RESTORE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      stack_pointer_restore_op |=> stack_top_pointer == 16'h01FF) else $error("restore failed");
   AST_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
      alu_valid && !flags_we && !rd_pend |=> condition_flags[1] == ($past(alu_result) == 8'h00)
      && condition_flags[2] == $past(alu_result[7])) else $error("zero or negative wrong");
   AST_IDX2: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !idx2_we |=> $stable(index2)) else $error("second index changed");
   AST_TAKE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      irq_req |=> irq_take == !(condition_flags[3] || busy)) else $error("request not held for service");
endmodule

// ### bench/cfs_stack_mem.sv
/*
 stack data memory model standing behind the register block.
 assumes writes land in the cycle of mem_we and read data comes one cycle after mem_re.
*/
module cfs_stack_mem (
   input wire logic clk_sys, // cpu clock
   input wire logic mem_we, // write strobe
   input wire logic mem_re, // read strobe
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] store [0:511]; // pages 0 and 1, the stack sits at 0180..01FF
   initial mem_rdata = 8'h00;
   // synchronous write, registered read
   always @(posedge clk_sys) begin
      if (mem_we) begin
         store[mem_addr[8:0]] <= mem_wdata;
      end
      if (mem_re) begin
         mem_rdata <= store[mem_addr[8:0]];
      end else begin
         mem_rdata <= ~mem_rdata; // idle bus toggles so stale data never passes for a read
      end
   end
endmodule

// ### bench/cfs_regs_tb.sv
/*
 self-checking bench for the cpu flag and stack pointer register set.
 assumes the design strobes are one-cycle and the stack memory model answers reads.
*/
module cfs_regs_tb;
   import cfs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, arst_n = 1'b0;
   logic acc_we = 0, idx1_we = 0, idx2_we = 0, ip_we = 0, alu_valid = 0, alu_is_add = 0;
   logic alu_half_carry = 0, alu_carry_upd = 0, alu_carry = 0, carry_set_op = 0, carry_clear_op = 0;
   logic mask_interrupts_op = 0, unmask_interrupts_op = 0, flags_we = 0, stack_pointer_restore_op = 0;
   logic load_op = 0, push_byte = 0, pop_byte = 0, irq_req = 0;
   logic [7:0] acc_wdata = 0, idx1_wdata = 0, idx2_wdata = 0, alu_result = 0, flags_wdata = 0;
   logic [7:0] load_data = 0, push_data = 0;
   logic [15:0] ip_wdata = 0;
   cfs_cmd_t cmd = CFS_CMD_NONE;
   logic [7:0] accumulator, index1, index2, condition_flags, pop_data, mem_wdata, mem_rdata;
   logic [15:0] instruction_pointer, stack_top_pointer, mem_addr;
   logic pop_valid, irq_take, busy, mem_we, mem_re;
   int err_total = 0, n_checks = 0, cyc = 0;
   logic [31:0] rnd = 32'hf8d6; // random state
   logic [7:0] exp_q [$]; // expected pop results, oldest first
   // 20 MHz cpu clock
   always #25 clk_sys = ~clk_sys;
   cfs_regs DUT (.clk_sys(clk_sys), .arst_n(arst_n), .acc_we(acc_we), .acc_wdata(acc_wdata),
      .idx1_we(idx1_we), .idx1_wdata(idx1_wdata), .idx2_we(idx2_we), .idx2_wdata(idx2_wdata),
      .ip_we(ip_we), .ip_wdata(ip_wdata), .alu_valid(alu_valid), .alu_result(alu_result),
      .alu_is_add(alu_is_add), .alu_half_carry(alu_half_carry), .alu_carry_upd(alu_carry_upd),
      .alu_carry(alu_carry), .carry_set_op(carry_set_op), .carry_clear_op(carry_clear_op),
      .mask_interrupts_op(mask_interrupts_op), .unmask_interrupts_op(unmask_interrupts_op),
      .flags_we(flags_we), .flags_wdata(flags_wdata), .stack_pointer_restore_op(stack_pointer_restore_op),
      .load_op(load_op), .load_data(load_data), .push_byte(push_byte), .push_data(push_data),
      .pop_byte(pop_byte), .cmd(cmd), .irq_req(irq_req), .accumulator(accumulator), .index1(index1),
      .index2(index2), .instruction_pointer(instruction_pointer), .condition_flags(condition_flags),
      .stack_top_pointer(stack_top_pointer), .pop_data(pop_data), .pop_valid(pop_valid),
      .irq_take(irq_take), .busy(busy), .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   cfs_stack_mem u_mem (.clk_sys(clk_sys), .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   // galois-free shift register step for stimulus values
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // one clock, inputs move a fixed 2 ns after the edge
   task automatic tick();
      @(posedge clk_sys);
      #2;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // frame command, then bounded wait for the sequencer and the restore slack
   task automatic run_cmd(input cfs_cmd_t c);
      int n;
      n = 0;
      cmd = c;
      tick();
      cmd = CFS_CMD_NONE;
      while (busy === 1'b1 && n < 20) begin
         tick();
         n++;
      end
      tick();
      tick();
   endtask
   task automatic test_done();
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // result watcher: each pop answer is matched against the oldest note
   always @(negedge clk_sys) begin
      if (pop_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(16'hDEAD, 16'h0000);
         end else begin
            check({8'h00, pop_data}, {8'h00, exp_q.pop_front()});
         end
      end
   end
   // hang guard, the sequence needs well under 400 cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         test_done();
      end
   end
   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      #2 arst_n = 1'b1;
      tick();
      check({8'h00, condition_flags}, 16'h00E8);
      check(stack_top_pointer, 16'h01FF);
      // alu results: sign, zero, half-carry and carry, first result forced to zero
      {alu_valid, alu_is_add, alu_carry_upd} = 3'b111;
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         alu_result = (i == 0) ? 8'h00 : rnd[7:0];
         {alu_half_carry, alu_carry} = rnd[9:8];
         tick();
         check({8'h00, condition_flags}, {8'h00, 3'b111, rnd[9], 1'b1, alu_result[7],
            alu_result == 8'h00, rnd[8]});
      end
      {alu_valid, alu_is_add, alu_carry_upd} = 3'b000;
      carry_set_op = 1'b1;
      tick();
      carry_set_op = 1'b0;
      check({15'h0, condition_flags[0]}, 16'h0001);
      carry_clear_op = 1'b1;
      tick();
      carry_clear_op = 1'b0;
      check({15'h0, condition_flags[0]}, 16'h0000);
      // direct flag write clears the mask
      flags_wdata = 8'h15;
      flags_we = 1'b1;
      tick();
      flags_we = 1'b0;
      check({8'h00, condition_flags}, 16'h00F5);
      // single push and pop, then wrap at both stack ends
      push_data = 8'h3C;
      push_byte = 1'b1;
      tick();
      push_byte = 1'b0;
      check(stack_top_pointer, 16'h01FE);
      check({8'h00, u_mem.store[9'h1FF]}, 16'h003C);
      exp_q.push_back(8'h3C);
      pop_byte = 1'b1;
      tick();
      pop_byte = 1'b0;
      check(stack_top_pointer, 16'h01FF);
      tick();
      tick();
      load_data = 8'h80; // bit 7 is fixed, low seven bits go to zero
      load_op = 1'b1;
      tick();
      load_op = 1'b0;
      check(stack_top_pointer, 16'h0180);
      push_data = 8'hA7;
      push_byte = 1'b1;
      tick();
      push_byte = 1'b0;
      check(stack_top_pointer, 16'h01FF);
      exp_q.push_back(8'hA7);
      pop_byte = 1'b1;
      tick();
      pop_byte = 1'b0;
      check(stack_top_pointer, 16'h0180);
      tick();
      tick();
      load_data = 8'h25;
      load_op = 1'b1;
      tick();
      load_op = 1'b0;
      stack_pointer_restore_op = 1'b1;
      tick();
      stack_pointer_restore_op = 1'b0;
      check(stack_top_pointer, 16'h01FF);
      // subroutine frame of two bytes
      rnd = lfsr(rnd);
      ip_wdata = rnd[15:0];
      ip_we = 1'b1;
      tick();
      ip_we = 1'b0;
      run_cmd(CFS_CMD_CALL);
      check(stack_top_pointer, 16'h01FD);
      check({u_mem.store[9'h1FE], u_mem.store[9'h1FF]}, ip_wdata);
      ip_wdata = 16'h0000;
      ip_we = 1'b1;
      tick();
      ip_we = 1'b0;
      run_cmd(CFS_CMD_RET);
      check(instruction_pointer, rnd[15:0]);
      check(stack_top_pointer, 16'h01FF);
      // masked request waits, unmask lets it through
      mask_interrupts_op = 1'b1;
      tick();
      mask_interrupts_op = 1'b0;
      irq_req = 1'b1;
      tick();
      irq_req = 1'b0;
      check({15'h0, irq_take}, 16'h0000);
      unmask_interrupts_op = 1'b1;
      tick();
      unmask_interrupts_op = 1'b0;
      check({15'h0, irq_take}, 16'h0001);
      {acc_wdata, idx1_wdata, idx2_wdata} = {8'h5A, 8'hC1, 8'h77};
      ip_wdata = 16'h1234;
      {acc_we, idx1_we, idx2_we, ip_we} = 4'hF;
      tick();
      {acc_we, idx1_we, idx2_we, ip_we} = 4'h0;
      check({accumulator, index1}, 16'h5AC1);
      run_cmd(CFS_CMD_IRQ);
      check(stack_top_pointer, 16'h01FA);
      check({15'h0, condition_flags[3]}, 16'h0001);
      check({u_mem.store[9'h1FF], u_mem.store[9'h1FE]}, 16'h3412);
      check({u_mem.store[9'h1FD], u_mem.store[9'h1FC]}, 16'hC15A);
      check({8'h00, u_mem.store[9'h1FB]}, 16'h00F5);
      // nested request inside the handler, taken once unmasked
      irq_req = 1'b1;
      tick();
      irq_req = 1'b0;
      check({15'h0, irq_take}, 16'h0000);
      unmask_interrupts_op = 1'b1;
      tick();
      unmask_interrupts_op = 1'b0;
      check({15'h0, irq_take}, 16'h0001);
      {acc_wdata, idx1_wdata, idx2_wdata} = 24'h0;
      ip_wdata = 16'h0000;
      {acc_we, idx1_we, idx2_we, ip_we} = 4'hF;
      tick();
      {acc_we, idx1_we, idx2_we, ip_we} = 4'h0;
      run_cmd(CFS_CMD_RETURN_FROM_INTERRUPT_OP);
      check({accumulator, index1}, 16'h5AC1);
      check(instruction_pointer, 16'h1234);
      check({8'h00, index2}, 16'h0000);
      check({8'h00, condition_flags}, 16'h00F5);
      check(stack_top_pointer, 16'h01FF);
      tick();
      check(16'(exp_q.size()), 16'h0000);
      test_done();
   end
endmodule
